// file: logic/prs_defines.vh
// Purpose: shared constants of the resource sequencer
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes:   definitions only, included by bare name
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH

// clock rates in hertz
`define PRS_PCLK_HZ         250000000
`define PRS_LPCLK_HZ        32768
// pclk cycles per sequencer tick, rounded down
`define PRS_TICK_CYC        (`PRS_PCLK_HZ / `PRS_LPCLK_HZ)

// register byte offsets
`define PRS_OFF_MIN         8'h00
`define PRS_OFF_CLKMAP0     8'h04
`define PRS_OFF_CLKMAP1     8'h08
`define PRS_OFF_RT_COUNT    8'h0c
`define PRS_OFF_RT_MASK     8'h10
`define PRS_OFF_STATE       8'h14
`define PRS_OFF_PENDING     8'h18
`define PRS_OFF_TBL_IDX     8'h1c
`define PRS_OFF_TBL_DEP     8'h20
`define PRS_OFF_TBL_TIME    8'h24

// resource bit positions
`define PRS_RES_LPLDO_A     0
`define PRS_RES_LPLDO_B     1
`define PRS_RES_BUCK        2
`define PRS_RES_CORE_LDO    3
`define PRS_RES_LN_LDO      4

// reset values
`define PRS_MIN_RESET       8'h1f
`define PRS_LP_ALWAYS       8'h03
`define PRS_DEP_ON_BUCK     8'h04
`define PRS_CLKMAP0_RESET   8'h24
`define PRS_CLKMAP1_RESET   8'h64

`endif

// file: logic/prs_time_mem.v
// Purpose: per-resource turn-on and turn-off delay table
// Assumes: one write port, one read port, registered read data
// Notes:   array itself has no reset, software loads it
`timescale 1ns/100ps
module prs_time_mem #(
    parameter DEPTH = 8,
    parameter AW    = 3,
    parameter DW    = 32
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_q
);
    reg [DW-1:0] mem [0:DEPTH-1];  // delay words

    // write port, no reset on storage
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data always comes out of a flop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= {DW{1'b0}};
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule // prs_time_mem

// file: logic/prs_req_timer.v
// Purpose: resource request timer counting sequencer ticks
// Assumes: tick is a one-cycle pulse
// Notes:   active while count is non-zero
`timescale 1ns/100ps
module prs_req_timer #(
    parameter CW = 16
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          clear,
    input  wire          load,
    input  wire [CW-1:0] load_val,
    input  wire          tick,
    output reg  [CW-1:0] count_q,
    output wire          active
);
    // load wins over tick, clear wins over both
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {CW{1'b0}};
        end else if (clear) begin
            count_q <= {CW{1'b0}};
        end else if (load) begin
            count_q <= load_val;
        end else if (tick && (count_q != {CW{1'b0}})) begin
            count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    assign active = (count_q != {CW{1'b0}});  // mask contributes while set
endmodule // prs_req_timer

// file: logic/prs_sequencer.v
// Purpose: resource sequencer enabling regulators and clock sources
// Assumes: APB slave, pclk 250 MHz, inputs synchronous to pclk
// Notes:   one scan pass over all resources per sequencer tick
// Contract
// - request from clocks, minimum mask, timers
// - map each clock request to resources
// - each resource in exactly one of four states
// - timer zero when settled, non-zero in transition
// - load timer with turn-on or turn-off delay
// - timers decrement once per sequencer tick
// - timer at zero completes the transition
// - zero turn-on delay enables immediately
// - zero turn-off delay disables immediately
// - recompute required set every tick with dependencies
// - decrement timers, at zero clear pending, invert
// - compare required set against current status
// - disable only enabled, unrequested, unused resources
// - enable only disabled, requested, dependencies met
// - power pin low drops main regulators together
// - core and low-noise regulators switch at runtime
// - lowest power keeps only low-power regulators
// - active mode adjusts clocks dynamically
// - power pin gates regulators and section reset
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "prs_defines.vh"
module prs_sequencer #(
    parameter NRES     = 8,
    parameter IW       = 3,
    parameter TW       = 16,
    parameter TICK_DIV = `PRS_TICK_CYC
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire [7:0]      paddr,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    input  wire [1:0]      clk_req,
    input  wire            wireless_power_on_pin,
    output reg  [NRES-1:0] res_enable,
    output reg             wireless_reset_n
);
    // scan states
    localparam S_IDLE = 2'd0;
    localparam S_READ = 2'd1;
    localparam S_EXEC = 2'd2;

    reg  [1:0]      st_q;           // scan state
    reg  [IW-1:0]   idx_q;          // resource being scanned
    reg  [13:0]     div_q;          // tick divider
    reg             tick_q;         // one-cycle sequencer tick
    reg  [NRES-1:0] min_q;          // minimum_resource_mask
    reg  [NRES-1:0] map0_q;         // resources behind clock 0
    reg  [NRES-1:0] map1_q;         // resources behind clock 1
    reg  [NRES-1:0] rt_mask_q;      // request timer mask
    reg  [IW-1:0]   tbl_idx_q;      // table entry selected by software
    reg  [NRES-1:0] state_q;        // resource_state_flag
    reg  [NRES-1:0] pend_q;         // resource_pending_flag
    reg  [NRES-1:0] st_s;           // state snapshot at tick
    reg  [NRES-1:0] pd_s;           // pending snapshot at tick
    reg  [NRES-1:0] req_s;          // required set snapshot
    reg  [TW-1:0]   tmr_q [0:NRES-1]; // per-resource countdown
    reg  [NRES-1:0] req_c;          // required set, combinational
    reg  [NRES-1:0] base_c;         // raw request before closure
    reg  [31:0]     rd_c;           // read mux
    reg             hit_c;          // address is mapped
    wire [NRES*NRES-1:0] dep_flat;  // dependency rows, packed
    wire [NRES*NRES-1:0] dcol;      // dependency columns, packed
    wire [NRES-1:0] used_w;         // resource has live dependents
    wire [2*TW-1:0] tm_rdata;       // delay word of scanned entry
    wire [TW-1:0]   rt_count;       // request timer remaining
    wire            rt_active;      // request timer running
    wire            acc;            // APB access edge
    wire            wr;             // APB write edge
    wire [TW-1:0]   t_on;           // turn-on delay of scanned entry
    wire [TW-1:0]   t_off;          // turn-off delay of scanned entry
    wire [TW-1:0]   t_cur;          // scanned entry timer
    wire            pin;            // power pin, synchronous input

    assign pin   = wireless_power_on_pin;
    assign acc   = psel & penable & pready;
    assign wr    = acc & pwrite;
    assign t_on  = tm_rdata[TW-1:0];
    assign t_off = tm_rdata[2*TW-1:TW];
    assign t_cur = tmr_q[idx_q];

    // delay table lives in its own memory
    prs_time_mem #(
        .DEPTH (NRES),
        .AW    (IW),
        .DW    (2*TW)
    ) u_time_mem (
        .clk     (pclk),
        .rst_n   (presetn),
        .we      (wr && (paddr == `PRS_OFF_TBL_TIME)),
        .waddr   (tbl_idx_q),
        .wdata   (pwdata[2*TW-1:0]),
        .raddr   (idx_q),
        .rdata_q (tm_rdata)
    );

    // request timer, cleared with the power pin
    prs_req_timer #(
        .CW (TW)
    ) u_req_timer (
        .clk      (pclk),
        .rst_n    (presetn),
        .clear    (!pin),
        .load     (wr && (paddr == `PRS_OFF_RT_COUNT)),
        .load_val (pwdata[TW-1:0]),
        .tick     (tick_q),
        .count_q  (rt_count),
        .active   (rt_active)
    );

    // dependency table, one row per resource
    genvar gi;
    genvar gj;
    generate
        for (gi = 0; gi < NRES; gi = gi + 1) begin : g_dep
            reg [NRES-1:0] dep_q;   // prerequisites of this resource
            // core and low-noise regulators need the buck by default
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    if (gi == `PRS_RES_CORE_LDO || gi == `PRS_RES_LN_LDO)
                    begin
                        dep_q <= `PRS_DEP_ON_BUCK;
                    end else begin
                        dep_q <= {NRES{1'b0}};
                    end
                end else if (wr && (paddr == `PRS_OFF_TBL_DEP) &&
                             (tbl_idx_q == gi)) begin
                    dep_q <= pwdata[NRES-1:0];
                end
            end
            assign dep_flat[gi*NRES +: NRES] = dep_q;
            // transpose: column gi lists who depends on gi
            for (gj = 0; gj < NRES; gj = gj + 1) begin : g_col
                assign dcol[gi*NRES+gj] = dep_flat[gj*NRES+gi];
            end
            // a dependent that is up or moving keeps gi alive
            assign used_w[gi] =
                |(dcol[gi*NRES +: NRES] & (st_s | pd_s));
        end
    endgenerate

    // request merge and dependency closure
    always @* begin : p_req
        integer k;
        integer j;
        k = 0;
        j = 0;
        base_c = min_q;
        if (clk_req[0]) begin
            base_c = base_c | map0_q;
        end
        if (clk_req[1]) begin
            base_c = base_c | map1_q;
        end
        if (rt_active) begin
            base_c = base_c | rt_mask_q;
        end
        // low-power regulators stay up whenever the pin is high
        base_c = base_c | `PRS_LP_ALWAYS;
        req_c = base_c;
        // each pass adds one level of prerequisites
        for (k = 0; k < NRES; k = k + 1) begin
            for (j = 0; j < NRES; j = j + 1) begin
                if (req_c[j]) begin
                    req_c = req_c | dep_flat[j*NRES +: NRES];
                end
            end
        end
        if (!pin) begin
            req_c = {NRES{1'b0}};
        end
    end

    // tick divider, derives the low-power rate from pclk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= 14'h0000;
            tick_q <= 1'b0;
        end else if (div_q == TICK_DIV[13:0] - 14'h0001) begin
            div_q  <= 14'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 14'h0001;
            tick_q <= 1'b0;
        end
    end

    // scan engine: snapshot at tick, then visit every resource
    always @(posedge pclk or negedge presetn) begin : p_scan
        integer n;
        if (!presetn) begin
            st_q    <= S_IDLE;
            idx_q   <= {IW{1'b0}};
            state_q <= {NRES{1'b0}};
            pend_q  <= {NRES{1'b0}};
            st_s    <= {NRES{1'b0}};
            pd_s    <= {NRES{1'b0}};
            req_s   <= {NRES{1'b0}};
            for (n = 0; n < NRES; n = n + 1) begin
                tmr_q[n] <= {TW{1'b0}};
            end
        end else if (!pin) begin
            // pin low: everything down at once, scan aborted
            st_q    <= S_IDLE;
            idx_q   <= {IW{1'b0}};
            state_q <= {NRES{1'b0}};
            pend_q  <= {NRES{1'b0}};
            for (n = 0; n < NRES; n = n + 1) begin
                tmr_q[n] <= {TW{1'b0}};
            end
        end else begin
            case (st_q)
                S_IDLE: begin
                    // freeze inputs so every entry sees one tick
                    if (tick_q) begin
                        st_s  <= state_q;
                        pd_s  <= pend_q;
                        req_s <= req_c;
                        idx_q <= {IW{1'b0}};
                        st_q  <= S_READ;
                    end
                end
                S_READ: begin
                    // delay word arrives from the memory next edge
                    st_q <= S_EXEC;
                end
                S_EXEC: begin
                    if (t_cur != {TW{1'b0}}) begin
                        // in transition: count down one tick
                        tmr_q[idx_q] <= t_cur -
                            {{(TW-1){1'b0}}, 1'b1};
                        if (t_cur == {{(TW-1){1'b0}}, 1'b1}) begin
                            pend_q[idx_q]  <= 1'b0;
                            state_q[idx_q] <= ~state_q[idx_q];
                        end
                    end else if (!pd_s[idx_q]) begin
                        if (st_s[idx_q] && !req_s[idx_q] &&
                            !used_w[idx_q]) begin
                            // settled on, unwanted, nobody leans on it
                            if (t_off == {TW{1'b0}}) begin
                                state_q[idx_q] <= 1'b0;
                            end else begin
                                pend_q[idx_q] <= 1'b1;
                                tmr_q[idx_q]  <= t_off;
                            end
                        end else if (!st_s[idx_q] && req_s[idx_q] &&
                            ((dep_flat[idx_q*NRES +: NRES] & ~st_s) ==
                             {NRES{1'b0}})) begin
                            // settled off, wanted, prerequisites up
                            if (t_on == {TW{1'b0}}) begin
                                state_q[idx_q] <= 1'b1;
                            end else begin
                                pend_q[idx_q] <= 1'b1;
                                tmr_q[idx_q]  <= t_on;
                            end
                        end
                    end
                    // decision above compares req_s with status
                    if (idx_q == NRES[IW-1:0] - {{(IW-1){1'b0}}, 1'b1})
                    begin
                        st_q <= S_IDLE;
                    end else begin
                        idx_q <= idx_q + {{(IW-1){1'b0}}, 1'b1};
                        st_q  <= S_READ;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // enables follow state_q: still off while turning on, still on while turning off
    // reset release follows the pin; outside logic raises it again
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_enable       <= {NRES{1'b0}};
            wireless_reset_n <= 1'b0;
        end else begin
            res_enable       <= state_q;
            wireless_reset_n <= pin;
        end
    end

    // software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_q     <= `PRS_MIN_RESET;
            map0_q    <= `PRS_CLKMAP0_RESET;
            map1_q    <= `PRS_CLKMAP1_RESET;
            rt_mask_q <= {NRES{1'b0}};
            tbl_idx_q <= {IW{1'b0}};
        end else if (wr) begin
            case (paddr)
                `PRS_OFF_MIN:     min_q     <= pwdata[NRES-1:0];
                `PRS_OFF_CLKMAP0: map0_q    <= pwdata[NRES-1:0];
                `PRS_OFF_CLKMAP1: map1_q    <= pwdata[NRES-1:0];
                `PRS_OFF_RT_MASK: rt_mask_q <= pwdata[NRES-1:0];
                `PRS_OFF_TBL_IDX: tbl_idx_q <= pwdata[IW-1:0];
                default: begin
                end
            endcase
        end
    end

    // read mux and decode; delay table is write-only
    always @* begin
        rd_c  = 32'h00000000;
        hit_c = 1'b1;
        case (paddr)
            `PRS_OFF_MIN:      rd_c[NRES-1:0] = min_q;
            `PRS_OFF_CLKMAP0:  rd_c[NRES-1:0] = map0_q;
            `PRS_OFF_CLKMAP1:  rd_c[NRES-1:0] = map1_q;
            `PRS_OFF_RT_COUNT: rd_c[TW-1:0]   = rt_count;
            `PRS_OFF_RT_MASK:  rd_c[NRES-1:0] = rt_mask_q;
            `PRS_OFF_STATE:    rd_c[NRES-1:0] = state_q;
            `PRS_OFF_PENDING:  rd_c[NRES-1:0] = pend_q;
            `PRS_OFF_TBL_IDX:  rd_c[IW-1:0]   = tbl_idx_q;
            `PRS_OFF_TBL_DEP:  rd_c[NRES-1:0] =
                               dep_flat[tbl_idx_q*NRES +: NRES];
            `PRS_OFF_TBL_TIME: rd_c = 32'h00000000;
            default:           hit_c = 1'b0;
        endcase
    end

    // APB answer: one access cycle, data captured in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_c;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_c;
            end
        end
    end
endmodule // prs_sequencer

// file: tb/prs_far_side.sv
// Purpose: far side of the sequencer, requesting cores and power pin
// Assumes: the bench tells the model what the cores want
// Notes:   requests are levels, changed just after a rising edge
`timescale 1ns/100ps
module prs_far_side (
    input  logic       pclk,
    input  logic       presetn,
    input  logic [1:0] want,
    input  logic       power_cmd,
    output logic [1:0] clk_req,
    output logic       wireless_power_on_pin
);
    // pin rests low like its pull-down until the host drives it
    initial wireless_power_on_pin = 1'b0;
    // cores hold a clock request for as long as they need the clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_req <= 2'b00;
        end else begin
            clk_req <= want;
        end
    end
    // only outside logic brings the chip back from power-down
    always @(posedge pclk) begin
        wireless_power_on_pin <= power_cmd;
    end
endmodule // prs_far_side

// file: tb/prs_monitor.sv
// Purpose: port checker of the resource sequencer
// Assumes: default dependency table, resources 3 and 4 need the buck
// Notes:   bound into every sequencer instance
`timescale 1ns/100ps
`include "prs_defines.vh"
module prs_monitor #(
    parameter NRES     = 8,
    parameter TICK_DIV = `PRS_TICK_CYC
) (
    input logic            pclk,
    input logic            presetn,
    input logic [7:0]      paddr,
    input logic            psel,
    input logic            penable,
    input logic            pready,
    input logic            pslverr,
    input logic            wireless_power_on_pin,
    input logic [NRES-1:0] res_enable,
    input logic            wireless_reset_n
);
    // first tick, one scan, output register, some slack
    localparam int LIM = TICK_DIV + 2 * NRES + 8;
    logic [31:0] wait_q;   // cycles powered with low-power rails off
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // counter instead of a long delay range, tick spacing is large
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 32'h0;
        end else if (!wireless_power_on_pin || &res_enable[1:0]) begin
            wait_q <= 32'h0;
        end else begin
            wait_q <= wait_q + 32'h1;
        end
    end
    property p_rdy;
        psel && !penable |=> pready && $past(psel) ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready not one cycle after setup");
    property p_err;
        psel && !penable && paddr[1:0] == 2'b00
            |=> pslverr == $past(paddr > `PRS_OFF_TBL_TIME);
    endproperty
    a_err: assert property (p_err)
        else $error("error flag wrong for address");
    property p_rst_follow;
        $past(presetn) |-> wireless_reset_n == $past(wireless_power_on_pin);
    endproperty
    a_rst_follow: assert property (p_rst_follow)
        else $error("section reset does not follow pin");
    property p_pin_off;
        !wireless_power_on_pin [*3] |-> res_enable == '0 && !wireless_reset_n;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("rails on while pin low");
    property p_lp_hold;
        &res_enable[1:0] && wireless_power_on_pin
            && $past(wireless_power_on_pin)
            |=> &res_enable[1:0];
    endproperty
    a_lp_hold: assert property (p_lp_hold)
        else $error("low-power rail dropped while powered");
    property p_lp_up;
        wait_q <= LIM;
    endproperty
    a_lp_up: assert property (p_lp_up)
        else $error("low-power rails not up in time");
    property p_core_dep;
        $rose(res_enable[3]) |-> $past(res_enable[2]);
    endproperty
    a_core_dep: assert property (p_core_dep)
        else $error("core rail on before buck");
    property p_ln_dep;
        $rose(res_enable[4]) |-> $past(res_enable[2]);
    endproperty
    a_ln_dep: assert property (p_ln_dep)
        else $error("low-noise rail on before buck");
    property p_buck_off;
        $fell(res_enable[2]) && $past(wireless_power_on_pin, 2)
            |-> !$past(res_enable[3]) && !$past(res_enable[4]);
    endproperty
    a_buck_off: assert property (p_buck_off)
        else $error("buck off under a dependent");
    c_core: cover property ($rose(res_enable[3]));
    c_pin: cover property ($fell(wireless_power_on_pin));
    c_err: cover property (pslverr);
endmodule // prs_monitor
bind prs_sequencer prs_monitor #(.NRES(NRES), .TICK_DIV(TICK_DIV))
    i_prs_monitor (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .wireless_power_on_pin(wireless_power_on_pin),
    .res_enable(res_enable), .wireless_reset_n(wireless_reset_n));

// file: tb/tb.sv
// Purpose: self-checking bench of the resource sequencer
// Assumes: tick spacing cut to 40 pclk, default dependency table
// Notes:   gaps between events are rounded to whole ticks
`timescale 1ns/100ps
`include "prs_defines.vh"
module tb;
    localparam int TD = 40;          // pclk per sequencer tick
    typedef struct {
        logic [7:0] mn;              // minimum mask
        logic [1:0] ck;              // core clock wants
        logic [7:0] ex;              // settled enables
    } prs_row_t;
    logic        pclk, presetn, psel, penable, pwrite, power_cmd, pin;
    logic        pready, pslverr, er, wireless_reset_n;
    logic [7:0]  paddr, res_enable;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  want, clk_req;
    int          miscompares = 0, checked = 0, cyc = 0, t0, t1;
    prs_row_t    rows [7] = '{'{8'h00, 2'b00, 8'h03},
        '{8'h04, 2'b00, 8'h07}, '{8'h08, 2'b00, 8'h0f},
        '{8'h00, 2'b01, 8'h27}, '{8'h00, 2'b10, 8'h67},
        '{8'h10, 2'b00, 8'h17}, '{8'h00, 2'b00, 8'h03}};
    prs_sequencer #(.TICK_DIV(TD)) i_prs_sequencer (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_req(clk_req), .wireless_power_on_pin(pin),
        .res_enable(res_enable), .wireless_reset_n(wireless_reset_n));
    prs_far_side i_prs_far_side (.pclk(pclk), .presetn(presetn),
        .want(want), .power_cmd(power_cmd), .clk_req(clk_req),
        .wireless_power_on_pin(pin));
    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // hang guard, far above the planned run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            finish_test;
        end
    end
    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer; the idle edge first keeps drivers single per step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask
    // waits for an enable bit, hang guard bounds it, notes the cycle
    task automatic wait_bit(input int b, input logic v, output int t);
        while (res_enable[b] !== v) begin
            @(posedge pclk);
        end
        t = cyc;
    endtask
    function automatic int ticks(input int a, input int b);
        return (b - a + TD / 2) / TD;
    endfunction
    // main sequence
    initial begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        want      = 2'b00;
        power_cmd = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`PRS_OFF_MIN, 32'h1f, 1'b0);
        rdc(`PRS_OFF_CLKMAP0, 32'h24, 1'b0);
        rdc(`PRS_OFF_CLKMAP1, 32'h64, 1'b0);
        rdc(`PRS_OFF_RT_MASK, 32'h0, 1'b0);
        rdc(`PRS_OFF_TBL_TIME, 32'h0, 1'b0);
        rdc(8'h28, 32'h0, 1'b1);
        // zero all delays while the section is held off
        for (int i = 0; i < 8; i++) begin
            wr(`PRS_OFF_TBL_IDX, 32'(i));
            wr(`PRS_OFF_TBL_TIME, 32'h0);
        end
        wr(`PRS_OFF_MIN, 32'h0);
        chk(32'(res_enable), 32'h0);
        power_cmd <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, wireless_reset_n}, 32'h1);
        foreach (rows[i]) begin
            wr(`PRS_OFF_MIN, {24'h0, rows[i].mn});
            want <= rows[i].ck;
            repeat (6 * TD) @(posedge pclk);
            chk(32'(res_enable), {24'h0, rows[i].ex});
        end
        // request timer adds the low-noise rail while it counts
        wr(`PRS_OFF_RT_MASK, 32'h10);
        wr(`PRS_OFF_RT_COUNT, 32'h8);
        repeat (5 * TD) @(posedge pclk);
        chk(32'(res_enable), 32'h17);
        repeat (10 * TD) @(posedge pclk);
        chk(32'(res_enable), 32'h03);
        // buck instant, core two ticks on and three ticks off
        wr(`PRS_OFF_TBL_IDX, 32'h3);
        wr(`PRS_OFF_TBL_TIME, 32'h0003_0002);
        wr(`PRS_OFF_MIN, 32'h08);
        wait_bit(2, 1'b1, t0);
        repeat (TD + TD / 2) @(posedge pclk);
        rdc(`PRS_OFF_PENDING, 32'h08, 1'b0);
        rdc(`PRS_OFF_STATE, 32'h07, 1'b0);
        rdc(`PRS_OFF_TBL_DEP, 32'h04, 1'b0);
        wait_bit(3, 1'b1, t1);
        chk(32'(ticks(t0, t1)), 32'h3);
        wr(`PRS_OFF_MIN, 32'h0);
        repeat (2 * TD) @(posedge pclk);
        rdc(`PRS_OFF_PENDING, 32'h08, 1'b0);
        chk({31'h0, res_enable[3]}, 32'h1);
        wait_bit(3, 1'b0, t0);
        wait_bit(2, 1'b0, t1);
        chk(32'(ticks(t0, t1)), 32'h1);
        // power pin drops every rail, raising it brings them back
        wr(`PRS_OFF_MIN, 32'h1f);
        repeat (8 * TD) @(posedge pclk);
        chk(32'(res_enable), 32'h1f);
        power_cmd <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(32'(res_enable), 32'h0);
        chk({31'h0, wireless_reset_n}, 32'h0);
        power_cmd <= 1'b1;
        repeat (8 * TD) @(posedge pclk);
        chk(32'(res_enable), 32'h1f);
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(res_enable), 32'h0);
        presetn <= 1'b1;
        rdc(`PRS_OFF_MIN, 32'h1f, 1'b0);
        repeat (8 * TD) @(posedge pclk);
        chk(32'(res_enable), 32'h1f);
        finish_test;
    end
endmodule // tb
